// *** logic/rss_reset_seq.v ***
// Reset source sequencer: hardware, software and watchdog reset control
// Operation
// - Pin low with pull-down sense low enters asynchronous hardware reset.
// - Sense falling during a synchronous reset switches at once to asynchronous.
// - Software reset instruction starts the internal sequence only when idle, with the filtered reset high.
// - Software reset acts short synchronous; keeps P0.12..8 latched, sets P0.7..2.
// - Software reset is always synchronous, whatever the pull-down sense level.
// - Bidirectional software reset drives the pin low only while sense is high.
// - Bidirectional drive is void for events arriving while sense is low.
// - Sense falling mid-sequence releases the pin yet the 1024 HALF_CLOCK_PERIOD sequence completes.
// - Filtered reset high soon after a bidirectional reset simply leaves reset.
// - Every reset sequence clears the bidirectional enable; software sets it again.
// - Reset length is classed from the filtered, delayed reset signal.
// - 8 HALF_CLOCK_PERIOD after bidirectional sequence, filtered low starts flagged hardware reset.
// - That degenerated reset is short unless the pin is held long.
// - Internal flash selection lengthens reset so no degeneration occurs.
// - All resets branch to vector 0, trap 0, at highest priority.
`timescale 1ns/100ps
`include "rss_reset_map.vh"

module rss_reset_seq #(
    parameter FLASH_INIT_CYC = 1024
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Reset pin, open drain
    input wire reset_in_pin_i,
    output wire reset_in_pin_o,
    output wire reset_in_pin_oe,
    // Other pins sampled during reset
    input wire reset_pulldown_sense,
    input wire external_access_select,
    input wire [15:0] port0_pins,
    // Events from the core and watchdog, same clock
    input wire software_reset_instr,
    input wire watchdog_overflow,
    // Software control
    input wire bidir_enable_set,
    input wire [3:0] flags_clear,
    // Reset state
    output wire internal_reset,
    output wire async_reset_active,
    output wire filtered_reset,
    output wire bidir_reset_enable,
    output wire [3:0] watchdog_control_flags,
    output wire [15:0] port0_latched,
    // Reset exception toward the core
    output wire reset_trap_req,
    output wire [23:0] reset_vector,
    output wire [7:0] reset_trap_number
);

    // ----------------------------------------------------------------
    // States and counts
    // ----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ASYNC = 3'h1;
    localparam [2:0] ST_SYNC = 3'h2;
    localparam [2:0] ST_SEQ = 3'h3;
    localparam [2:0] ST_FLASH = 3'h4;
    localparam [2:0] ST_POST = 3'h5;
    localparam [2:0] ST_DONE = 3'h6;

    localparam integer SEQ_LAST = `RSS_SEQ_CYC - 1;
    localparam integer POST_LAST = `RSS_POST_CYC - 1;
    localparam integer FILT_LAST = `RSS_FILT_CYC - 1;
    localparam integer LONG_MIN = `RSS_LONG_CYC;
    localparam integer FLASH_LAST = FLASH_INIT_CYC - 1;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    wire [18:0] sync_out;
    wire pin_s;
    wire rpd_s;
    wire ea_s;
    wire [15:0] p0_s;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [10:0] cnt_reg;
    reg [10:0] cnt_next;
    reg [10:0] low_reg;
    reg [10:0] low_next;
    reg [1:0] kind_reg;
    reg [1:0] kind_next;
    reg drive_reg;
    reg drive_next;
    reg bidir_used_reg;
    reg bidir_used_next;
    reg bidir_en_reg;
    reg bidir_en_next;
    reg [3:0] flags_reg;
    reg [3:0] flags_next;
    reg [5:0] filt_cnt_reg;
    reg filt_reg;
    reg [15:0] p0_reg;
    reg [15:0] p0_next;
    reg oe_reg;
    reg pin_o_reg;
    reg int_rst_reg;
    reg async_reg;
    reg trap_req_reg;
    reg [23:0] vector_reg;
    reg [7:0] trap_num_reg;
    reg [3:0] ev_flags;
    reg ev_write;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    rss_pin_sync #(
        .WIDTH(19),
        .RST_VAL(19'h7ffff)
    ) u_pin_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .pin_in({port0_pins, external_access_select, reset_pulldown_sense, reset_in_pin_i}),
        .pin_out(sync_out)
    );

    assign pin_s = sync_out[0];
    assign rpd_s = sync_out[1];
    assign ea_s = sync_out[2];
    assign p0_s = sync_out[18:3];

    // ----------------------------------------------------------------
    // Reset pin input filter
    // ----------------------------------------------------------------
    // Both edges wait out the filter, so the release is seen late too
    always @(posedge clock) begin
        if (sys_rst) begin
            filt_reg <= 1'b1;
            filt_cnt_reg <= 6'h00;
        end else if (pin_s == filt_reg) begin
            filt_cnt_reg <= 6'h00;
        end else if (filt_cnt_reg == FILT_LAST[5:0]) begin
            filt_reg <= pin_s;
            filt_cnt_reg <= 6'h00;
        end else begin
            filt_cnt_reg <= filt_cnt_reg + 6'h01;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer next state
    // ----------------------------------------------------------------
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        low_next = low_reg;
        kind_next = kind_reg;
        drive_next = drive_reg;
        bidir_used_next = bidir_used_reg;
        bidir_en_next = bidir_en_reg | bidir_enable_set;
        ev_write = 1'b0;
        ev_flags = `RSS_FLG_RST;
        p0_next = p0_reg;
        case (state_reg)
            ST_IDLE: begin
                cnt_next = 11'h000;
                low_next = 11'h001;
                drive_next = 1'b0;
                bidir_used_next = 1'b0;
                if (!filt_reg) begin
                    // Hardware reset has precedence over internal events
                    kind_next = `RSS_KIND_HW;
                    bidir_en_next = 1'b0;
                    if (!rpd_s) begin
                        state_next = ST_ASYNC;
                    end else begin
                        state_next = ST_SYNC;
                    end
                end else if (watchdog_overflow || software_reset_instr) begin
                    // Always synchronous, sense only gates the pin drive
                    state_next = ST_SEQ;
                    kind_next = watchdog_overflow ? `RSS_KIND_WDT : `RSS_KIND_SW;
                    drive_next = bidir_en_reg & rpd_s;
                    bidir_used_next = bidir_en_reg & rpd_s;
                    bidir_en_next = 1'b0;
                    ev_write = 1'b1;
                    ev_flags[`RSS_FLG_WDTR] = watchdog_overflow;
                    ev_flags[`RSS_FLG_SWR] = ~watchdog_overflow;
                end
            end
            ST_ASYNC: begin
                if (low_reg != 11'h7ff) begin
                    low_next = low_reg + 11'h001;
                end
                if (filt_reg) begin
                    state_next = ST_SEQ;
                    cnt_next = 11'h000;
                    ev_write = 1'b1;
                    ev_flags[`RSS_FLG_LHWR] = 1'b1;
                    ev_flags[`RSS_FLG_SHWR] = 1'b1;
                    ev_flags[`RSS_FLG_SWR] = 1'b1;
                end
            end
            ST_SYNC: begin
                if (low_reg != 11'h7ff) begin
                    low_next = low_reg + 11'h001;
                end
                if (!filt_reg && !rpd_s) begin
                    state_next = ST_ASYNC;
                end else if (filt_reg) begin
                    // Length judged on the filtered signal; short may read long
                    state_next = ST_SEQ;
                    cnt_next = 11'h000;
                    ev_write = 1'b1;
                    ev_flags[`RSS_FLG_LHWR] = (low_reg >= LONG_MIN[10:0]);
                    ev_flags[`RSS_FLG_SHWR] = 1'b1;
                    ev_flags[`RSS_FLG_SWR] = 1'b1;
                end
            end
            ST_SEQ: begin
                cnt_next = cnt_reg + 11'h001;
                if (!rpd_s) begin
                    drive_next = 1'b0;
                end
                if (cnt_reg == SEQ_LAST[10:0]) begin
                    // Sequence always runs to its full length
                    cnt_next = 11'h000;
                    drive_next = 1'b0;
                    if (ea_s) begin
                        state_next = ST_FLASH;
                    end else if (bidir_used_reg) begin
                        state_next = ST_POST;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_FLASH: begin
                // Flash setup outlasts the filter, so no post sampling is needed
                cnt_next = cnt_reg + 11'h001;
                if (cnt_reg == FLASH_LAST[10:0]) begin
                    state_next = ST_DONE;
                end
            end
            ST_POST: begin
                cnt_next = cnt_reg + 11'h001;
                if (cnt_reg == POST_LAST[10:0]) begin
                    cnt_next = 11'h000;
                    low_next = 11'h001;
                    kind_next = `RSS_KIND_HW;
                    // A degenerated hardware reset gets no second post check
                    bidir_used_next = 1'b0;
                    if (!filt_reg) begin
                        state_next = ST_SYNC;
                    end else begin
                        state_next = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
                if (kind_reg == `RSS_KIND_SW) begin
                    p0_next[`RSS_P0_KEEP_HI:`RSS_P0_KEEP_LO] =
                        p0_s[`RSS_P0_KEEP_HI:`RSS_P0_KEEP_LO];
                    p0_next[`RSS_P0_SET_HI:`RSS_P0_SET_LO] = 6'h3f;
                end else begin
                    p0_next = p0_s;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // A new cause replaces the old; clearing never beats an event
        if (ev_write) begin
            flags_next = ev_flags;
        end else begin
            flags_next = flags_reg & ~flags_clear;
        end
    end

    // ----------------------------------------------------------------
    // Sequencer registers
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 11'h000;
            low_reg <= 11'h000;
            kind_reg <= `RSS_KIND_HW;
            drive_reg <= 1'b0;
            bidir_used_reg <= 1'b0;
            bidir_en_reg <= 1'b0;
            flags_reg <= `RSS_FLG_RST;
            p0_reg <= `RSS_P0_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            low_reg <= low_next;
            kind_reg <= kind_next;
            drive_reg <= drive_next;
            bidir_used_reg <= bidir_used_next;
            bidir_en_reg <= bidir_en_next;
            flags_reg <= flags_next;
            p0_reg <= p0_next;
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    // Pin and core reset follow the next state so they change with it
    always @(posedge clock) begin
        if (sys_rst) begin
            oe_reg <= 1'b0;
            pin_o_reg <= 1'b0;
            int_rst_reg <= 1'b1;
            async_reg <= 1'b0;
            trap_req_reg <= 1'b0;
            vector_reg <= `RSS_RST_VECTOR;
            trap_num_reg <= `RSS_RST_TRAP;
        end else begin
            oe_reg <= (state_next == ST_SEQ) && drive_next;
            pin_o_reg <= 1'b0;
            int_rst_reg <= (state_next != ST_IDLE);
            async_reg <= (state_next == ST_ASYNC);
            trap_req_reg <= (state_reg == ST_DONE);
            vector_reg <= `RSS_RST_VECTOR;
            trap_num_reg <= `RSS_RST_TRAP;
        end
    end

    assign reset_in_pin_o = pin_o_reg;
    assign reset_in_pin_oe = oe_reg;
    assign internal_reset = int_rst_reg;
    assign async_reset_active = async_reg;
    assign filtered_reset = filt_reg;
    assign bidir_reset_enable = bidir_en_reg;
    assign watchdog_control_flags = flags_reg;
    assign port0_latched = p0_reg;
    assign reset_trap_req = trap_req_reg;
    assign reset_vector = vector_reg;
    assign reset_trap_number = trap_num_reg;

endmodule // rss_reset_seq

// *** logic/rss_reset_map.vh ***
// Timing constants, field positions and codes of the reset source sequencer
`ifndef RSS_RESET_MAP_VH
`define RSS_RESET_MAP_VH

// ----------------------------------------------------------------
// Clock and half clock period, in picoseconds
// ----------------------------------------------------------------
`define RSS_CLK_PS 25000
`define RSS_TCL_PS 12500

// ----------------------------------------------------------------
// Times in their own unit and the derived cycle counts
// ----------------------------------------------------------------
// Internal reset sequence length, a least time, rounded up
`define RSS_SEQ_TCL 1024
`define RSS_SEQ_CYC ((`RSS_SEQ_TCL * `RSS_TCL_PS + `RSS_CLK_PS - 1) / `RSS_CLK_PS)
// Delay from end of sequence to sampling of the filtered reset
`define RSS_POST_TCL 8
`define RSS_POST_CYC ((`RSS_POST_TCL * `RSS_TCL_PS + `RSS_CLK_PS - 1) / `RSS_CLK_PS)
// Input filter on the reset pin
`define RSS_FILT_NS 500
`define RSS_FILT_CYC ((`RSS_FILT_NS * 1000 + `RSS_CLK_PS - 1) / `RSS_CLK_PS)
// Low time past which a synchronous reset counts as long: 1032 + 12 HALF_CLOCK_PERIOD plus the filter
`define RSS_LONG_TCL 1044
`define RSS_LONG_CYC ((`RSS_LONG_TCL * `RSS_TCL_PS + `RSS_CLK_PS - 1) / `RSS_CLK_PS + `RSS_FILT_CYC)

// ----------------------------------------------------------------
// Reset source flag positions
// ----------------------------------------------------------------
`define RSS_FLG_WDTR 0
`define RSS_FLG_SWR 1
`define RSS_FLG_SHWR 2
`define RSS_FLG_LHWR 3
`define RSS_FLG_W 4
`define RSS_FLG_RST 4'h0

// ----------------------------------------------------------------
// Port 0 fields on a software reset
// ----------------------------------------------------------------
`define RSS_P0_KEEP_HI 12
`define RSS_P0_KEEP_LO 8
`define RSS_P0_SET_HI 7
`define RSS_P0_SET_LO 2
`define RSS_P0_RST 16'hffff

// ----------------------------------------------------------------
// Reset vector and trap number
// ----------------------------------------------------------------
`define RSS_RST_VECTOR 24'h000000
`define RSS_RST_TRAP 8'h00

// ----------------------------------------------------------------
// Source kinds
// ----------------------------------------------------------------
`define RSS_KIND_HW 2'h0
`define RSS_KIND_SW 2'h1
`define RSS_KIND_WDT 2'h2

`endif

// *** logic/rss_pin_sync.v ***
// Three-stage pin synchroniser: a rise passes once stages two and three agree, a fall as soon as stage two drops
`timescale 1ns/100ps

module rss_pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Asynchronous pins
    input wire [WIDTH-1:0] pin_in,
    // Synchronised level
    output wire [WIDTH-1:0] pin_out
);

    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    reg [WIDTH-1:0] out_reg;

    // ----------------------------------------------------------------
    // Synchroniser chain
    // ----------------------------------------------------------------
    // First stage feeds the second only, to keep metastability contained
    always @(posedge clock) begin
        if (sys_rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            out_reg <= RST_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= (s2_reg & s3_reg) | (out_reg & ~(s2_reg ^ s3_reg)); // Agree
        end
    end

    assign pin_out = out_reg;

endmodule // rss_pin_sync

// *** sim/rss_reset_props.sv ***
// Assertion checker on the reset source sequencer ports
`timescale 1ns/100ps

module rss_reset_props #(
    parameter FLASH_INIT_CYC = 1024
) (
    // Clock and reset
    input wire clock,
    input wire sys_rst,
    // Block inputs
    input wire reset_pulldown_sense,
    input wire software_reset_instr,
    input wire watchdog_overflow,
    input wire [3:0] flags_clear,
    // Block outputs
    input wire reset_in_pin_oe,
    input wire internal_reset,
    input wire async_reset_active,
    input wire filtered_reset,
    input wire bidir_reset_enable,
    input wire [3:0] watchdog_control_flags,
    input wire reset_trap_req,
    input wire [23:0] reset_vector,
    input wire [7:0] reset_trap_number
);
    default clocking dc @(posedge clock); endclocking
    default disable iff (sys_rst);

    // Cycles in reset so far; a sequence cut short shows at its end
    reg [15:0] len_reg;
    always @(posedge clock) begin
        if (sys_rst || !internal_reset) begin
            len_reg <= 16'h0000;
        end else begin
            len_reg <= len_reg + 16'h0001;
        end
    end

    sequence s_idle;
        !internal_reset && filtered_reset;
    endsequence
    sequence s_quiet;
        s_idle ##0 (!software_reset_instr && !watchdog_overflow);
    endsequence
    sequence s_hw_async;
        ($fell(filtered_reset) && !internal_reset) ##1
            (!filtered_reset && !reset_pulldown_sense) [*6];
    endsequence

    property p_sw_take;
        s_idle ##0 (software_reset_instr && !watchdog_overflow) |=>
            internal_reset && watchdog_control_flags == 4'h2;
    endproperty
    property p_wdt_take;
        s_idle ##0 watchdog_overflow |=> internal_reset && watchdog_control_flags == 4'h1;
    endproperty
    property p_bidir_clr;
        $rose(internal_reset) |-> !bidir_reset_enable;
    endproperty
    property p_oe_cause;
        $rose(reset_in_pin_oe) |-> $rose(internal_reset) && $past(bidir_reset_enable);
    endproperty
    property p_oe_sense;
        (!reset_pulldown_sense) [*8] |-> !reset_in_pin_oe;
    endproperty
    property p_async;
        s_hw_async |=> async_reset_active;
    endproperty
    property p_exit;
        $fell(internal_reset) && !$past(sys_rst) && !$past(sys_rst, 2) |->
            reset_trap_req && len_reg >= 16'h0200;
    endproperty
    property p_trap_vec;
        reset_trap_req |-> reset_vector == 24'h000000 && reset_trap_number == 8'h00
            ##1 !reset_trap_req;
    endproperty
    property p_flags;
        s_quiet |=> watchdog_control_flags ==
            ($past(watchdog_control_flags) & ~$past(flags_clear));
    endproperty

    a_sw_take: assert property (p_sw_take) else $error("software reset not taken");
    a_wdt_take: assert property (p_wdt_take) else $error("watchdog reset not taken");
    a_bidir_clr: assert property (p_bidir_clr) else $error("bidir enable kept");
    a_oe_cause: assert property (p_oe_cause) else $error("pin driven without cause");
    a_oe_sense: assert property (p_oe_sense) else $error("pin driven, sense low");
    a_async: assert property (p_async) else $error("async reset missed");
    a_exit: assert property (p_exit) else $error("reset exit wrong");
    a_trap_vec: assert property (p_trap_vec) else $error("trap request wrong");
    a_flags: assert property (p_flags) else $error("flags changed while idle");
endmodule // rss_reset_props

// *** sim/rss_ext_reset.sv ***
// External reset circuitry: pull-up on the reset pin and a timed pull-down
`timescale 1ns/100ps

module rss_ext_reset (
    // Clock
    input wire clock,
    // Command from the bench
    input wire start,
    input wire [11:0] hold_cyc,
    // Block side of the open-drain pin
    input wire reset_in_pin_o,
    input wire reset_in_pin_oe,
    // Resolved pin level
    output wire reset_in_pin
);
    reg [11:0] cnt_reg = 12'h000;

    // Pull low for the commanded count; real requests outlast the filter
    always @(posedge clock) begin
        if (start) begin
            cnt_reg <= hold_cyc;
        end else if (cnt_reg != 12'h000) begin
            cnt_reg <= cnt_reg - 12'h001;
        end
    end

    // Wired-AND with pull-up, so a released pin reads high
    assign reset_in_pin = !((cnt_reg != 12'h000) || (reset_in_pin_oe && !reset_in_pin_o));
endmodule // rss_ext_reset

// *** sim/tb.sv ***
// Self-checking bench for the reset source sequencer
`timescale 1ns/100ps

bind rss_reset_seq rss_reset_props #(.FLASH_INIT_CYC(FLASH_INIT_CYC)) u_props (
    .clock(clock), .sys_rst(sys_rst), .reset_pulldown_sense(reset_pulldown_sense),
    .software_reset_instr(software_reset_instr), .watchdog_overflow(watchdog_overflow),
    .flags_clear(flags_clear), .reset_in_pin_oe(reset_in_pin_oe),
    .internal_reset(internal_reset), .async_reset_active(async_reset_active),
    .filtered_reset(filtered_reset), .bidir_reset_enable(bidir_reset_enable),
    .watchdog_control_flags(watchdog_control_flags), .reset_trap_req(reset_trap_req),
    .reset_vector(reset_vector), .reset_trap_number(reset_trap_number)
);

module tb;
    // Short flash init, still longer than synchroniser plus pin filter
    localparam FLASH = 64;
    reg clock = 1'b0;
    reg sys_rst = 1'b1;
    reg sense = 1'b1;
    reg ea = 1'b0;
    reg [15:0] p0 = 16'h0000;
    reg sw = 1'b0;
    reg wdt = 1'b0;
    reg bd_set = 1'b0;
    reg [3:0] clr = 4'h0;
    reg ext_go = 1'b0;
    reg [11:0] ext_hold = 12'h000;
    wire pin, pin_o, pin_oe, irst, async_on, filt, bd_en, trap;
    wire [3:0] flags;
    wire [15:0] p0_lat;
    wire [23:0] vec;
    wire [7:0] trap_no;
    integer errors = 0;
    integer samples_checked = 0;
    integer n;
    integer i;
    reg [31:0] rnd;
    reg [15:0] lat_m;
    reg [3:0] exp_fl;

    always #12.5 clock = ~clock;

    rss_reset_seq #(.FLASH_INIT_CYC(FLASH)) dut (
        .clock(clock), .sys_rst(sys_rst),
        .reset_in_pin_i(pin), .reset_in_pin_o(pin_o), .reset_in_pin_oe(pin_oe),
        .reset_pulldown_sense(sense), .external_access_select(ea), .port0_pins(p0),
        .software_reset_instr(sw), .watchdog_overflow(wdt),
        .bidir_enable_set(bd_set), .flags_clear(clr),
        .internal_reset(irst), .async_reset_active(async_on), .filtered_reset(filt),
        .bidir_reset_enable(bd_en), .watchdog_control_flags(flags), .port0_latched(p0_lat),
        .reset_trap_req(trap), .reset_vector(vec), .reset_trap_number(trap_no)
    );

    rss_ext_reset ext (
        .clock(clock), .start(ext_go), .hold_cyc(ext_hold),
        .reset_in_pin_o(pin_o), .reset_in_pin_oe(pin_oe), .reset_in_pin(pin)
    );

    // Software reset keeps the upper port field and sets the lower one
    function automatic [15:0] sw_lat(input [15:0] prev, input [15:0] pins);
        sw_lat = prev;
        sw_lat[12:8] = pins[12:8];
        sw_lat[7:2] = 6'h3f;
    endfunction

    task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tick(input integer k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    // One-cycle event pulse; returns once the taking edge has landed
    task automatic evt(input bit w);
        @(posedge clock);
        wdt <= w;
        sw <= !w;
        @(posedge clock);
        wdt <= 1'b0;
        sw <= 1'b0;
        #1;
    endtask

    // Bounded wait for reset to end, then the exit trap
    task automatic wait_idle;
        n = 0;
        while (irst !== 1'b0 && n < 4000) begin
            tick(1);
            n = n + 1;
        end
        chk("trap_req", trap, 1'b1);
        chk("vector", {vec[23:8], vec[7:0] | trap_no}, 24'h000000);
    endtask

    task automatic bidir_evt(input bit w, input bit e);
        @(posedge clock);
        ea <= e;
        bd_set <= 1'b1;
        @(posedge clock);
        bd_set <= 1'b0;
        tick(4);
        chk("bidir_en", bd_en, 1'b1);
        evt(w);
        chk("bidir_en", bd_en, 1'b0);
    endtask

    task automatic press(input [11:0] h);
        @(posedge clock);
        ext_go <= 1'b1;
        ext_hold <= h;
        @(posedge clock);
        ext_go <= 1'b0;
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short; tests need about 9000 cycles
    initial begin
        repeat (40000) @(posedge clock);
        errors = errors + 1;
        give_verdict;
    end

    initial begin
        rnd = $urandom(54699);
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        tick(2);
        chk("flags", flags, 4'h0);
        chk("bidir_en", bd_en, 1'b0);
        chk("port0", p0_lat, 16'hffff);
        lat_m = 16'hffff;
        $display("reset values test done");
        // Software and watchdog resets, corner then random port values
        for (i = 0; i < 6; i = i + 1) begin
            rnd = $urandom;
            exp_fl = i[0] ? 4'h1 : 4'h2;
            @(posedge clock);
            p0 <= (i < 2) ? {16{i[0]}} : rnd[15:0];
            ea <= i[1];
            tick(4);
            evt(i[0]);
            chk("flags", flags, exp_fl);
            wait_idle;
            chk("seq_len", n >= 512 + (i[1] ? FLASH : 0), 1'b1);
            lat_m = i[0] ? p0 : sw_lat(lat_m, p0);
            chk("port0", p0_lat, lat_m);
            tick(3);
            chk("flags_hold", flags, exp_fl);
            @(posedge clock);
            clr <= rnd[19:16];
            @(posedge clock);
            clr <= 4'h0;
            #1;
            chk("flags_clr", flags, exp_fl & ~rnd[19:16]);
        end
        $display("software and watchdog test done");
        // Bidirectional: degeneration, flash, sense loss mid-way, sense low
        bidir_evt(1'b0, 1'b0);
        chk("pin_oe", pin_oe, 1'b1);
        tick(2);
        chk("pin", pin, 1'b0);
        wait_idle;
        chk("flags", flags, 4'h6);
        chk("port0", p0_lat, p0);
        bidir_evt(1'b1, 1'b1);
        wait_idle;
        chk("flags", flags, 4'h1);
        bidir_evt(1'b1, 1'b0);
        tick(100);
        chk("pin_oe", pin_oe, 1'b1);
        @(posedge clock);
        sense <= 1'b0;
        tick(8);
        chk("pin_oe", pin_oe, 1'b0);
        chk("in_reset", irst, 1'b1);
        wait_idle;
        chk("seq_len", n + 110 >= 512, 1'b1);
        chk("flags", flags, 4'h1);
        bidir_evt(1'b0, 1'b0);
        chk("pin_oe", pin_oe, 1'b0);
        tick(30);
        chk("async", async_on, 1'b0);
        wait_idle;
        chk("flags", flags, 4'h2);
        $display("bidirectional test done");
        // Hardware: asynchronous, sense drop, short, long, filtered glitch
        press(12'h028);
        tick(30);
        chk("async", async_on, 1'b1);
        wait_idle;
        chk("port0", p0_lat, p0);
        @(posedge clock);
        sense <= 1'b1;
        tick(8);
        press(12'h0c8);
        tick(40);
        chk("async", async_on, 1'b0);
        @(posedge clock);
        sense <= 1'b0;
        tick(8);
        chk("async", async_on, 1'b1);
        wait_idle;
        @(posedge clock);
        sense <= 1'b1;
        for (i = 0; i < 2; i = i + 1) begin
            press(i ? 12'h258 : 12'h028);
            tick(30);
            chk("in_reset", irst, 1'b1);
            wait_idle;
            chk("flags", flags, i ? 4'he : 4'h6);
        end
        press(12'h00a);
        tick(40);
        chk("filtered", filt, 1'b1);
        chk("in_reset", irst, 1'b0);
        $display("hardware reset test done");
        give_verdict;
    end
endmodule // tb
